// *** mdspi_consts.vh ***
// constants for the motor driver serial slave: offsets, fields, resets, timing
// assumes a 100 MHz system clock; included by mdspi_slave.v and by the assertion checker
`ifndef MDSPI_CONSTS_VH
`define MDSPI_CONSTS_VH

// register addresses (five-bit address field)
`define MDSPI_ADDR_WDOG 5'h00
`define MDSPI_ADDR_CTRL3 5'h03
`define MDSPI_ADDR_STAT0 5'h04
`define MDSPI_ADDR_STAT3 5'h07

// command byte layout
`define MDSPI_CMD_TYPE_POS 7
`define MDSPI_CMD_ADDR_MSB 4

// watchdog_control fields
`define MDSPI_WD_ARM_POS 7
`define MDSPI_WD_SEL_MSB 6
`define MDSPI_WD_SEL_LSB 3

// sleep bit inside control register 3
`define MDSPI_SLEEP_POS 6

// warm boot flag position inside status register 0
`define MDSPI_WARM_POS 6
// status input bits that the flags may set (warm boot is internal)
`define MDSPI_STAT_IN_MASK 28'hfffffbf

// reset values
`define MDSPI_CTRL_RST 8'h00
`define MDSPI_STAT_RST 28'h0000000
`define MDSPI_SYNC_RST 6'h01

// transfer framing
`define MDSPI_WRITE_BITS 5'h10
`define MDSPI_PKT_SAT 5'h1f

// timing
`define MDSPI_CLK_MHZ 100
`define MDSPI_WD_UNIT_MS 32

`endif

// *** mdspi_slave.v ***
// motor driver serial slave: mode 0 serial port, control and status
// registers, watchdog, sleep gating and the active-low fault output.
// assumes every pin input is asynchronous to clock; the serial clock is
// slow enough (80 ns period) to be oversampled by the 100 MHz clock.
//
// Notes on behaviour
// [RULE_01] sleep: drivers high impedance, analog off, registers kept
// [RULE_02] sleep ignores step and direction input edges
// [RULE_03] sleep keeps serial and hard clear; clocks gated
// [RULE_04] clearing sleep resumes; master waits pump settle
// [RULE_05] device is slave only, never starts transfers
// [RULE_06] chip select high releases open-drain data output
// [RULE_07] mode 0: out on falling, sample rising
// [RULE_08] msb first; first byte holds command and address
// [RULE_09] command bit 0 reads, 1 writes; five-bit address
// [RULE_10] output shift loads on every eighth falling edge
// [RULE_11] byte received during read is next command
// [RULE_12] status bit 7 is odd parity of bits 6..0
// [RULE_13] reading a status register clears status registers
// [RULE_14] status and fault update only with chip select high
// [RULE_15] write commits on first clock with select high
// [RULE_16] write needs exactly sixteen bits, else discarded
// [RULE_17] each byte returns register at last address
// [RULE_18] writes to read-only registers change nothing
// [RULE_19] master ignores first output after power-on
// [RULE_20] read after write returns old value first
// [RULE_21] control registers read/write, no parity, reset zero
// [RULE_22] arm bit 1 restarts watchdog; 0 clears warm flag
// [RULE_23] watchdog timeout is 32 ms times code plus one
// [RULE_24] fault output low while any error flag set
// [RULE_25] command bit 7, address bits 4..0, 6..5 ignored
// [RULE_26] select high resets bit counter to byte boundary
`timescale 1ns/1ps
`include "mdspi_consts.vh"
`default_nettype none

module mdspi_slave #(
    parameter [31:0] WDOG_UNIT_CYCLES = `MDSPI_WD_UNIT_MS * 1000 * `MDSPI_CLK_MHZ
) (
    input wire clock,
    input wire srst,
    input wire chip_select_n,
    input wire serialClk,
    input wire serial_in,
    output wire serialOut,
    output reg serialOutEn,
    input wire step_pulse_in,
    input wire directionIn,
    input wire hard_clear_in,
    input wire [27:0] statusFlagsIn,
    output wire fault_out_n,
    output reg faultOutEn,
    output reg stepEvent,
    output reg directionOut,
    output reg high_impedance,
    output reg analogShutdown,
    output wire clocksActive,
    output reg watchdogResetPulse
);

    // pin synchronisers: bit 0 select, 1 clock, 2 data, 3 step, 4 dir, 5 clear
    reg [5:0] syncA_reg;
    reg [5:0] syncB_reg;
    reg [5:0] syncC_reg;
    reg [5:0] pinFilt_reg;
    reg [5:0] pinPrev_reg;
    wire [5:0] pinFilt_next;

    // serial engine state
    reg [2:0] bitCnt_reg;
    reg [4:0] pktBits_reg;
    reg [7:0] rxShift_reg;
    reg [7:0] txShift_reg;
    reg [7:0] pendData_reg;
    reg [4:0] curAddr_reg;
    reg byteIsData_reg;
    reg firstWrite_reg;
    reg byteDone_reg;
    reg statusReadSeen_reg;
    // last finished byte was a read command; writes must not clear status
    reg readCmd_reg;

    // register storage
    reg [7:0] ctrlReg [0:3];
    reg [27:0] statReg_reg;
    reg warmBoot_reg;

    // watchdog
    reg wdRun_reg;
    reg [31:0] wdCnt_reg;

    // read mux result
    reg [7:0] readData;
    reg [6:0] statBits;

    wire csLow;
    wire csRise;
    wire sclkRise;
    wire sclkFall;
    wire sdiBit;
    wire rstAll;
    wire [7:0] rxByte;
    wire sleepMode;
    wire commitWrite;
    wire [4:0] wdMult;
    wire [36:0] wdLimit;
    wire wdTimeout;
    integer i;

    // a change counts only once the second and third stages agree
    assign pinFilt_next = (syncB_reg & syncC_reg) | (pinFilt_reg & (syncB_reg ^ syncC_reg));

    // three-stage synchronisers and the filtered pin levels
    always @(posedge clock) begin
        if (srst) begin
            syncA_reg <= `MDSPI_SYNC_RST;
            syncB_reg <= `MDSPI_SYNC_RST;
            syncC_reg <= `MDSPI_SYNC_RST;
            pinFilt_reg <= `MDSPI_SYNC_RST;
            pinPrev_reg <= `MDSPI_SYNC_RST;
        end else begin
            syncA_reg <= {hard_clear_in, directionIn, step_pulse_in,
                          serial_in, serialClk, chip_select_n};
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            pinFilt_reg <= pinFilt_next;
            pinPrev_reg <= pinFilt_reg;
        end
    end

    // hard clear acts as a second synchronous reset of all digital logic after the pin filters
    assign rstAll = srst | pinFilt_reg[5]; // RULE_03

    assign csLow = ~pinFilt_reg[0];
    assign csRise = pinFilt_reg[0] & ~pinPrev_reg[0];
    // sampling on rising, shifting on falling: mode 0 only
    assign sclkRise = pinFilt_reg[1] & ~pinPrev_reg[1]; // RULE_07
    assign sclkFall = ~pinFilt_reg[1] & pinPrev_reg[1]; // RULE_07
    assign sdiBit = pinFilt_reg[2];
    // msb arrives first, so new bits enter at the bottom
    assign rxByte = {rxShift_reg[6:0], sdiBit}; // RULE_08

    assign sleepMode = ctrlReg[3][`MDSPI_SLEEP_POS];

    // read mux: control bytes plain, status bytes carry parity in bit 7
    always @* begin
        statBits = 7'h00;
        readData = 8'h00;
        if (curAddr_reg <= `MDSPI_ADDR_CTRL3) begin
            readData = ctrlReg[curAddr_reg[1:0]]; // RULE_21
        end else if (curAddr_reg <= `MDSPI_ADDR_STAT3) begin
            case (curAddr_reg[1:0])
                2'h0: statBits = statReg_reg[6:0];
                2'h1: statBits = statReg_reg[13:7];
                2'h2: statBits = statReg_reg[20:14];
                default: statBits = statReg_reg[27:21];
            endcase
            if (curAddr_reg == `MDSPI_ADDR_STAT0) begin
                statBits[`MDSPI_WARM_POS] = warmBoot_reg;
            end
            readData = {^statBits, statBits}; // RULE_12
        end
    end

    // serial engine; purely driven by the master's edges, never self-started
    always @(posedge clock) begin // RULE_05
        if (rstAll) begin
            bitCnt_reg <= 3'h0;
            pktBits_reg <= 5'h00;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'hff;
            pendData_reg <= 8'h00;
            curAddr_reg <= 5'h00;
            byteIsData_reg <= 1'b0;
            firstWrite_reg <= 1'b0;
            byteDone_reg <= 1'b0;
            statusReadSeen_reg <= 1'b0;
            readCmd_reg <= 1'b0;
        end else if (!csLow) begin
            // idle: realign to a byte boundary for the next packet
            bitCnt_reg <= 3'h0; // RULE_26
            pktBits_reg <= 5'h00; // RULE_26
            byteIsData_reg <= 1'b0; // RULE_26
            byteDone_reg <= 1'b0;
            readCmd_reg <= 1'b0;
            // the status block consumes this flag in the same cycle
            statusReadSeen_reg <= 1'b0;
        end else begin
            if (sclkRise) begin
                rxShift_reg <= rxByte;
                bitCnt_reg <= bitCnt_reg + 3'h1;
                // count every clocked bit so odd lengths can be detected
                if (pktBits_reg != `MDSPI_PKT_SAT) begin
                    pktBits_reg <= pktBits_reg + 5'h01; // RULE_16
                end
                if (bitCnt_reg == 3'h7) begin
                    byteDone_reg <= 1'b1;
                    if (byteIsData_reg) begin
                        // second byte of a write: data, not a command
                        pendData_reg <= rxByte;
                        byteIsData_reg <= 1'b0;
                        readCmd_reg <= 1'b0;
                    end else begin
                        // every non-data byte is a command, also during reads
                        curAddr_reg <= rxByte[`MDSPI_CMD_ADDR_MSB:0]; // RULE_25
                        byteIsData_reg <= rxByte[`MDSPI_CMD_TYPE_POS]; // RULE_09
                        readCmd_reg <= ~rxByte[`MDSPI_CMD_TYPE_POS]; // RULE_18
                        if (pktBits_reg == 5'h07) begin
                            firstWrite_reg <= rxByte[`MDSPI_CMD_TYPE_POS]; // RULE_11
                        end
                    end
                end
            end
            if (sclkFall) begin
                if (byteDone_reg) begin
                    // eighth falling edge: take the register at the last address
                    txShift_reg <= readData; // RULE_10 RULE_20
                    byteDone_reg <= 1'b0;
                    if (readCmd_reg && curAddr_reg >= `MDSPI_ADDR_STAT0 &&
                        curAddr_reg <= `MDSPI_ADDR_STAT3) begin
                        statusReadSeen_reg <= 1'b1; // RULE_13
                    end
                end else begin
                    // old contents keep going out until the next load
                    txShift_reg <= {txShift_reg[6:0], 1'b1}; // RULE_17
                end
            end
        end
    end

    // open drain: only ever pulls low, and only while selected
    assign serialOut = 1'b0;

    // enable tracks the outgoing bit; released whenever select is high
    always @(posedge clock) begin
        if (rstAll) begin
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= csLow & ~txShift_reg[7]; // RULE_06
        end
    end

    // a write is kept only when exactly sixteen bits framed it
    assign commitWrite = csRise & firstWrite_reg &
                         (pktBits_reg == `MDSPI_WRITE_BITS); // RULE_16

    // control registers; commit waits for the first cycle with select high
    always @(posedge clock) begin
        if (rstAll) begin
            for (i = 0; i < 4; i = i + 1) begin
                ctrlReg[i] <= `MDSPI_CTRL_RST; // RULE_21
            end
        end else if (commitWrite && curAddr_reg <= `MDSPI_ADDR_CTRL3) begin
            // status addresses and the unmapped space fall through untouched
            ctrlReg[curAddr_reg[1:0]] <= pendData_reg; // RULE_15 RULE_18
        end
    end

    // status latch: frozen while selected so a read sees a stable frame
    always @(posedge clock) begin
        if (rstAll) begin
            statReg_reg <= `MDSPI_STAT_RST;
        end else if (!csLow) begin
            // new flags still land in the clearing cycle: set beats clear
            if (statusReadSeen_reg) begin
                statReg_reg <= statusFlagsIn & `MDSPI_STAT_IN_MASK; // RULE_13
            end else begin
                statReg_reg <= statReg_reg | (statusFlagsIn & `MDSPI_STAT_IN_MASK); // RULE_14
            end
        end
    end

    // fault output follows the latched flags, also only with select high
    always @(posedge clock) begin
        if (rstAll) begin
            faultOutEn <= 1'b0;
        end else if (!csLow) begin
            faultOutEn <= |statReg_reg; // RULE_24 RULE_14
        end
    end

    // open drain fault pin: low level driven while enabled
    assign fault_out_n = 1'b0;

    // watchdog interval: unit period times code plus one
    assign wdMult = {1'b0, ctrlReg[0][`MDSPI_WD_SEL_MSB:`MDSPI_WD_SEL_LSB]} + 5'h01;
    assign wdLimit = {5'h00, WDOG_UNIT_CYCLES} * {32'h0, wdMult}; // RULE_23
    assign wdTimeout = wdRun_reg && ({5'h00, wdCnt_reg} >= wdLimit - 37'h1);

    // watchdog timer; a rewrite of the arm bit restarts the count
    always @(posedge clock) begin
        if (rstAll) begin
            wdRun_reg <= 1'b0;
            wdCnt_reg <= 32'h0;
            watchdogResetPulse <= 1'b0;
        end else begin
            watchdogResetPulse <= wdTimeout;
            if (commitWrite && curAddr_reg == `MDSPI_ADDR_WDOG) begin
                // arm bit 1 starts or restarts, 0 stops
                wdRun_reg <= pendData_reg[`MDSPI_WD_ARM_POS]; // RULE_22
                wdCnt_reg <= 32'h0; // RULE_22
            end else if (wdTimeout) begin
                // expiry resets the controller and waits to be re-armed
                wdRun_reg <= 1'b0;
                wdCnt_reg <= 32'h0;
            end else if (wdRun_reg) begin
                wdCnt_reg <= wdCnt_reg + 32'h1;
            end
        end
    end

    // warm boot flag: set on expiry, cleared by writing arm bit 0
    always @(posedge clock) begin
        if (rstAll) begin
            warmBoot_reg <= 1'b0;
        end else if (wdTimeout) begin
            // an expiry in the clearing cycle is not lost
            warmBoot_reg <= 1'b1;
        end else if (commitWrite && curAddr_reg == `MDSPI_ADDR_WDOG &&
                     !pendData_reg[`MDSPI_WD_ARM_POS]) begin
            warmBoot_reg <= 1'b0; // RULE_22
        end
    end

    // sleep gating of the motor side; registers themselves are never cleared
    always @(posedge clock) begin
        if (rstAll) begin
            high_impedance <= 1'b0;
            analogShutdown <= 1'b0;
            stepEvent <= 1'b0;
            directionOut <= 1'b0;
        end else begin
            high_impedance <= sleepMode; // RULE_01
            analogShutdown <= sleepMode; // RULE_01
            // leaving sleep just lifts the gate; pump settling is the master's wait
            stepEvent <= ~sleepMode & pinFilt_reg[3] & ~pinPrev_reg[3]; // RULE_02 RULE_04
            if (!sleepMode) begin
                directionOut <= pinFilt_reg[4]; // RULE_02
            end
        end
    end

    // in sleep the digital clocks only run while a transfer is selected
    assign clocksActive = ~sleepMode | csLow; // RULE_03

endmodule

`default_nettype wire

// *** mdspi_assertions.sv ***
// concurrent checks on the motor driver serial slave ports
// assumes a bind onto mdspi_slave; one clock domain, srst as reset
`timescale 1ns/1ps
`include "mdspi_consts.vh"
`default_nettype none
module mdspi_checker #(
    parameter [31:0] WDOG_UNIT_CYCLES = 32'd20
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic chip_select_n,
    input wire logic serialOutEn,
    input wire logic [27:0] statusFlagsIn,
    input wire logic faultOutEn,
    input wire logic high_impedance,
    input wire logic analogShutdown,
    input wire logic stepEvent,
    input wire logic clocksActive,
    input wire logic watchdogResetPulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // six clocks of select high outlast the pin filters
    property p_release; chip_select_n [*6] |-> !serialOutEn; endproperty
    a_release: assert property (p_release) else $error("data driven deselected");
    property p_fault_hold; !chip_select_n [*8] |=> $stable(faultOutEn); endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault moved");
    // writes commit only once select is back high
    property p_sleep_hold; !chip_select_n [*8] |=> $stable(high_impedance); endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("early commit");
    property p_fault;
        (chip_select_n && (statusFlagsIn & `MDSPI_STAT_IN_MASK) != 28'h0) [*8] |-> faultOutEn;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not raised");
    property p_analog; high_impedance |-> analogShutdown; endproperty
    a_analog: assert property (p_analog) else $error("analog left on");
    property p_no_step; high_impedance [*8] |-> !stepEvent; endproperty
    a_no_step: assert property (p_no_step) else $error("step in sleep");
    // asleep and idle: clocks stopped one cycle ahead of the gated flag
    property p_clk_off; (high_impedance && chip_select_n) [*7] |-> !$past(clocksActive); endproperty
    a_clk_off: assert property (p_clk_off) else $error("clocks run asleep");
    property p_wd_pulse; watchdogResetPulse |=> !watchdogResetPulse; endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("long expiry pulse");
endmodule
`default_nettype wire

// *** mdspi_spi_master.sv ***
// partner model: mode 0 serial master framing packets on the slave pins
// assumes the bench resolves the pulled-up data line into misoLine
`timescale 1ns/1ps
`default_nettype none
module mdspi_spi_master (
    input wire logic clock,
    output logic chip_select_n,
    output logic serialClk,
    output logic serial_in,
    input wire logic misoLine
);
    initial begin
        chip_select_n = 1'b1; // idle deselected
        serialClk = 1'b0; // idles low
        serial_in = 1'b0;
    end
    // one packet, msb first; only the master starts a frame
    task automatic xfer(input int nBits, input logic [23:0] txBits, output logic [23:0] rxBits);
        int i;
        rxBits = 24'h0;
        @(posedge clock);
        chip_select_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (i = nBits - 1; i >= 0; i--) begin
            serial_in <= txBits[i];
            repeat (4) @(posedge clock);
            serialClk <= 1'b1;
            repeat (4) @(posedge clock);
            // late sample: slave pin filters and output registers add about six clocks
            rxBits[i] = misoLine;
            serialClk <= 1'b0;
        end
        repeat (8) @(posedge clock);
        chip_select_n <= 1'b1;
        serial_in <= ~serial_in; // released line shows the inverse
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// *** mdspi_tb.sv ***
// self-checking bench for the motor driver serial slave
// assumes mdspi_slave, its header, the checker and the master model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int UNIT = 20; // short watchdog unit keeps the run brief
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic step_pulse_in = 1'b0;
    logic directionIn = 1'b0;
    logic hard_clear_in = 1'b0;
    logic [27:0] statusFlagsIn = 28'h0;
    wire logic chip_select_n, serialClk, serial_in, serialOut, serialOutEn;
    wire logic fault_out_n, faultOutEn, stepEvent, directionOut, high_impedance;
    wire logic analogShutdown, clocksActive, watchdogResetPulse;
    wire logic misoLine = serialOutEn ? serialOut : 1'b1; // pull-up when released
    int error_cnt = 0;
    int n_tests = 0;
    int cycleCnt = 0;
    int pulseAt = 0;
    int stepCnt = 0;
    logic [23:0] rx;
    always #5 clock = ~clock;
    mdspi_slave #(.WDOG_UNIT_CYCLES(UNIT)) dut (.clock(clock), .srst(srst),
        .chip_select_n(chip_select_n), .serialClk(serialClk), .serial_in(serial_in),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .step_pulse_in(step_pulse_in),
        .directionIn(directionIn), .hard_clear_in(hard_clear_in),
        .statusFlagsIn(statusFlagsIn), .fault_out_n(fault_out_n), .faultOutEn(faultOutEn),
        .stepEvent(stepEvent), .directionOut(directionOut), .high_impedance(high_impedance),
        .analogShutdown(analogShutdown), .clocksActive(clocksActive),
        .watchdogResetPulse(watchdogResetPulse));
    mdspi_spi_master master (.clock(clock), .chip_select_n(chip_select_n),
        .serialClk(serialClk), .serial_in(serial_in), .misoLine(misoLine));
    // cycle count, event capture and hang guard
    always @(posedge clock) begin
        cycleCnt <= cycleCnt + 1;
        if (watchdogResetPulse) pulseAt <= cycleCnt;
        if (stepEvent) stepCnt <= stepCnt + 1;
        if (cycleCnt == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        master.xfer(16, {8'h0, 3'b100, a, d}, rx);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        master.xfer(16, {8'h0, 3'b000, a, 8'h0}, rx);
        check(what, exp, rx[7:0]);
    endtask
    task automatic pulse_step;
        step_pulse_in <= 1'b1;
        directionIn <= ~directionIn;
        repeat (12) @(posedge clock);
        step_pulse_in <= 1'b0;
        repeat (12) @(posedge clock);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // first returned byte after power-up is never judged
    task automatic t_reset_values;
        int i;
        for (i = 0; i < 4; i++) rd(i[4:0], 8'h00, "reset");
    endtask
    task automatic t_sleep;
        master.xfer(16, {8'h0, 8'h83, 8'h40}, rx);
        check("old on write", 8'h00, rx[7:0]);
        check("sleep", 8'h01, {7'h0, high_impedance});
        check("clocks idle", 8'h00, {7'h0, clocksActive});
        pulse_step();
        check("sleep steps", 8'h00, stepCnt[7:0]);
        check("sleep dir", 8'h00, {7'h0, directionOut});
        master.xfer(16, {8'h0, 8'h03, 8'h00}, rx);
        check("stale", 8'h00, rx[15:8]);
        check("read back", 8'h40, rx[7:0]);
    endtask
    task automatic t_bad_length;
        master.xfer(24, {8'h83, 16'h0}, rx);
        master.xfer(8, {16'h0, 8'h83}, rx);
        check("odd length", 8'h01, {7'h0, high_impedance});
        wr(5'h03, 8'h00);
        check("awake", 8'h00, {7'h0, analogShutdown});
        repeat (20) @(posedge clock);
        check("awake dir", 8'h01, {7'h0, directionOut});
        pulse_step();
        check("awake steps", 8'h01, stepCnt[7:0]);
        master.xfer(16, {8'h0, 8'he1, 8'h5a}, rx);
        rd(5'h01, 8'h5a, "spare bits");
    endtask
    task automatic t_hard_clear;
        wr(5'h03, 8'h40);
        hard_clear_in <= 1'b1;
        repeat (8) @(posedge clock);
        hard_clear_in <= 1'b0;
        repeat (8) @(posedge clock);
        check("pin clear", 8'h00, {7'h0, high_impedance});
        rd(5'h01, 8'h00, "cleared");
    endtask
    task automatic t_status;
        statusFlagsIn <= 28'h0000203;
        repeat (12) @(posedge clock);
        check("fault", 8'h01, {7'h0, faultOutEn});
        check("fault pin", 8'h00, {7'h0, faultOutEn ? fault_out_n : 1'b1});
        statusFlagsIn <= 28'h0;
        master.xfer(24, {8'h04, 8'h05, 8'h00}, rx);
        check("even parity", 8'h03, rx[15:8]);
        check("odd parity", 8'h84, rx[7:0]);
        check("cleared", 8'h00, {7'h0, faultOutEn});
        statusFlagsIn <= 28'h0000001;
        repeat (8) @(posedge clock);
        statusFlagsIn <= 28'h0;
        wr(5'h04, 8'hff);
        rd(5'h04, 8'h81, "read-only");
    endtask
    task automatic t_watchdog;
        int t0;
        wr(5'h00, 8'h88);
        t0 = cycleCnt - 8;
        repeat (60) @(posedge clock);
        check("expiry", 8'h01, {7'h0, pulseAt - t0 >= 2 * UNIT && pulseAt - t0 <= 2 * UNIT + 8});
        rd(5'h04, 8'hc0, "warm set");
        wr(5'h00, 8'h00);
        rd(5'h04, 8'h00, "warm clear");
    endtask
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        repeat (8) @(posedge clock);
        t_reset_values();
        t_sleep();
        t_bad_length();
        t_hard_clear();
        t_status();
        t_watchdog();
        test_done();
    end
endmodule
bind mdspi_slave mdspi_checker #(.WDOG_UNIT_CYCLES(WDOG_UNIT_CYCLES)) chk (.clock(clock),
    .srst(srst), .chip_select_n(chip_select_n), .serialOutEn(serialOutEn),
    .statusFlagsIn(statusFlagsIn), .faultOutEn(faultOutEn), .high_impedance(high_impedance),
    .analogShutdown(analogShutdown), .stepEvent(stepEvent), .clocksActive(clocksActive),
    .watchdogResetPulse(watchdogResetPulse));
`default_nettype wire
